// >>> verilog/vdh_pkg.sv
// Constants and types for the video decoder register-access bus master.
// Assumes a 200 MHz system clock and open-drain SCL/SDA resolved outside.
package vdh_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 5;
  localparam int BIT_NS = 2500;
  localparam int QTR_NS = BIT_NS / 4;
  localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int US_NS = 1000;
  localparam int WAIT_US = 64;
  localparam int CNT_W = 24;

  // ==========================================================
  // Slave address and subaddress ranges
  localparam logic [6:0] ADDR_BASE = 7'h5C;
  localparam int ADDR_SEL_POS = 0;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;
  localparam logic [7:0] NOWAIT_FIRST = 8'h90;

  // ==========================================================
  // Types
  typedef enum logic {
    OP_WRITE = 1'b0,
    OP_READ = 1'b1
  } vdh_op_t;

  typedef struct packed {
    vdh_op_t op;
    logic strap;
    logic reinit;
    logic [7:0] subaddr;
    logic [3:0] len_m1;
  } vdh_cmd_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } vdh_pins_t;

endpackage // vdh_pkg

// >>> verilog/vdh_host.sv
// Bus master that writes and reads the video decoder's control registers.
// Assumes SCL/SDA pull-ups outside; pin inputs are asynchronous to clock.
//
// How it works
// R01 - Write starts: start, address, direction zero
// R02 - Subaddress then data bytes, MSB first
// R03 - Device stores bytes at successive registers
// R04 - Device acknowledges every received byte
// R05 - Write ends with stop after last ack
// R06 - Read phase one: subaddress, then stop
// R07 - Read phase two: start, address, direction one
// R08 - Master acks each read byte but last
// R09 - Not-acknowledge last byte, then stop
// R10 - Read address follows strap level
// R11 - Wait while device holds SCL low
// R12 - Wait 64 us before stop, low registers
// R13 - No wait for subaddresses 90h and up
// R14 - Longer wait for reinitialising registers
// R15 - Write address follows strap level
// R16 - Device latches strap at power-up
// R17 - Read continues from last written subaddress
// R18 - Device ignores foreign addresses, idles on stop
module vdh_host #(
  parameter int WAIT_NS = vdh_pkg::WAIT_US * vdh_pkg::US_NS,
  parameter int REINIT_WAIT_NS = 500000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Command
  input wire logic cmd_valid,
  input wire vdh_pkg::vdh_cmd_t cmd,
  output logic cmd_ready,
  // Write data
  input wire logic [7:0] wdata,
  output logic wdata_take,
  // Read data and status
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nack_err,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output vdh_pkg::vdh_pins_t pins
);

  localparam int WAIT_CYC = (WAIT_NS + vdh_pkg::CLK_NS - 1) / vdh_pkg::CLK_NS;
  localparam int LONG_CYC =
    (REINIT_WAIT_NS + vdh_pkg::CLK_NS - 1) / vdh_pkg::CLK_NS;
  localparam logic [vdh_pkg::CNT_W-1:0] QTR_LD =
    vdh_pkg::CNT_W'(vdh_pkg::QTR_CYC - 1);
  localparam logic [vdh_pkg::CNT_W-1:0] WAIT_LD =
    vdh_pkg::CNT_W'(WAIT_CYC - 1);
  localparam logic [vdh_pkg::CNT_W-1:0] LONG_LD =
    vdh_pkg::CNT_W'(LONG_CYC - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_SEND = 3'b010,
    ST_RECV = 3'b011,
    ST_HOLD = 3'b100,
    ST_STOP = 3'b101
  } vdh_state_t;

  typedef enum logic [1:0] {
    SQ_AW = 2'b00,
    SQ_SUB = 2'b01,
    SQ_WD = 2'b10,
    SQ_AR = 2'b11
  } vdh_seq_t;

  // ==========================================================
  // Pin synchronisers
  logic scl_s1, scl_s2, sda_s1, sda_s2;

  always_ff @(posedge clock) begin
    if (rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
    end
  end

  // ==========================================================
  // Sequencer
  vdh_state_t state_reg, state_next;
  vdh_seq_t seq_reg, seq_next;
  vdh_pkg::vdh_cmd_t cmd_reg, cmd_next;
  vdh_pkg::vdh_pins_t pins_reg, pins_next;
  logic [vdh_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [1:0] ph_reg, ph_next;
  logic [3:0] bit_reg, bit_next;
  logic [3:0] left_reg, left_next;
  logic [7:0] shreg_reg, shreg_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic ack_reg, ack_next;
  logic rph2_reg, rph2_next;
  logic ready_reg, ready_next;
  logic wtake_reg, wtake_next;
  logic rdv_reg, rdv_next;
  logic done_reg, done_next;
  logic err_reg, err_next;
  logic tick, stalled, byte_end;
  logic [6:0] addr7;

  assign addr7 = vdh_pkg::ADDR_BASE |
    7'(cmd_reg.strap << vdh_pkg::ADDR_SEL_POS);
  // Clock stretch: high quarters do not count while SCL is held low
  assign stalled = (state_reg == ST_SEND || state_reg == ST_RECV ||
    state_reg == ST_STOP) && ph_reg[1] && !scl_s2; // R11
  assign tick = (cnt_reg == '0) && !stalled;
  assign byte_end = tick && ph_reg == 2'h3 && bit_reg == 4'h8 &&
    (state_reg == ST_SEND || state_reg == ST_RECV);

  always_comb begin
    state_next = state_reg;
    seq_next = seq_reg;
    cmd_next = cmd_reg;
    pins_next = pins_reg;
    cnt_next = cnt_reg;
    ph_next = ph_reg;
    bit_next = bit_reg;
    left_next = left_reg;
    shreg_next = shreg_reg;
    rd_data_next = rd_data_reg;
    ack_next = ack_reg;
    rph2_next = rph2_reg;
    err_next = err_reg;
    wtake_next = 1'b0;
    rdv_next = 1'b0;
    done_next = 1'b0;
    if (state_reg != ST_IDLE && !stalled && cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
    if (state_reg != ST_IDLE && tick) begin
      cnt_next = QTR_LD;
      ph_next = ph_reg + 2'h1;
    end
    case (state_reg)
      ST_IDLE: begin
        if (cmd_valid && ready_reg) begin
          cmd_next = cmd;
          left_next = cmd.len_m1;
          err_next = 1'b0;
          rph2_next = 1'b0;
          seq_next = SQ_AW;
          cnt_next = QTR_LD;
          ph_next = 2'h0;
          state_next = ST_START;
        end
      end
      ST_START: begin
        if (tick) begin
          case (ph_reg)
            2'h0: pins_next.sda_oe = 1'b1; // R01
            2'h1: begin
              pins_next.scl_oe = 1'b1;
              ph_next = 2'h0;
              bit_next = 4'h0;
              state_next = ST_SEND;
              shreg_next = {addr7, (seq_reg == SQ_AR) ?
                vdh_pkg::DIR_READ : vdh_pkg::DIR_WRITE}; // R07 R10 R15
            end
            default: ph_next = 2'h0;
          endcase
        end
      end
      ST_SEND, ST_RECV: begin
        if (tick) begin
          case (ph_reg)
            2'h0: begin
              if (bit_reg == 4'h8) begin
                pins_next.sda_oe = (state_reg == ST_RECV) &&
                  (left_reg != 4'h0); // R08 R09
              end else begin
                pins_next.sda_oe = (state_reg == ST_SEND) &&
                  !shreg_reg[3'(7 - bit_reg)]; // R02
              end
            end
            2'h1: pins_next.scl_oe = 1'b0;
            2'h2: begin
              if (bit_reg == 4'h8) begin
                ack_next = !sda_s2;
              end else if (state_reg == ST_RECV) begin
                shreg_next = {shreg_reg[6:0], sda_s2}; // R08
              end
            end
            default: begin
              pins_next.scl_oe = 1'b1;
              bit_next = bit_reg + 4'h1;
            end
          endcase
        end
        if (byte_end) begin
          bit_next = 4'h0;
          if (state_reg == ST_RECV) begin
            rd_data_next = shreg_reg;
            rdv_next = 1'b1;
            if (left_reg != 4'h0) begin
              left_next = left_reg - 4'h1;
            end else begin
              state_next = ST_STOP; // R09
            end
          end else if (!ack_reg) begin
            err_next = 1'b1;
            state_next = ST_STOP;
          end else begin
            case (seq_reg)
              SQ_AW: begin
                shreg_next = cmd_reg.subaddr; // R02
                seq_next = SQ_SUB;
              end
              SQ_SUB: begin
                if (cmd_reg.op == vdh_pkg::OP_READ) begin
                  rph2_next = 1'b1;
                  state_next = ST_STOP; // R06
                end else begin
                  shreg_next = wdata;
                  wtake_next = 1'b1;
                  seq_next = SQ_WD;
                end
              end
              SQ_WD: begin
                if (left_reg != 4'h0) begin
                  left_next = left_reg - 4'h1;
                  shreg_next = wdata;
                  wtake_next = 1'b1;
                end else if (cmd_reg.subaddr < vdh_pkg::NOWAIT_FIRST) begin
                  state_next = ST_HOLD; // R12 R13
                  cnt_next = cmd_reg.reinit ? LONG_LD : WAIT_LD; // R14
                end else begin
                  state_next = ST_STOP; // R05 R13
                end
              end
              default: begin
                state_next = ST_RECV;
                pins_next.sda_oe = 1'b0;
              end
            endcase
          end
        end
      end
      ST_HOLD: begin
        ph_next = 2'h0;
        if (cnt_reg == '0) begin
          cnt_next = QTR_LD;
          state_next = ST_STOP; // R12
        end
      end
      ST_STOP: begin
        if (tick) begin
          case (ph_reg)
            2'h0: pins_next.sda_oe = 1'b1;
            2'h1: pins_next.scl_oe = 1'b0;
            2'h2: pins_next.sda_oe = 1'b0; // R05 R09
            default: begin
              ph_next = 2'h0;
              if (rph2_reg && !err_reg) begin
                rph2_next = 1'b0;
                seq_next = SQ_AR;
                state_next = ST_START; // R07
              end else begin
                done_next = 1'b1;
                state_next = ST_IDLE;
              end
            end
          endcase
        end
      end
      default: state_next = ST_IDLE;
    endcase
    ready_next = (state_next == ST_IDLE);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      seq_reg <= SQ_AW;
      cmd_reg <= '0;
      pins_reg <= '0;
      cnt_reg <= '0;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      left_reg <= 4'h0;
      shreg_reg <= 8'h00;
      rd_data_reg <= 8'h00;
      ack_reg <= 1'b0;
      rph2_reg <= 1'b0;
      ready_reg <= 1'b0;
      wtake_reg <= 1'b0;
      rdv_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      seq_reg <= seq_next;
      cmd_reg <= cmd_next;
      pins_reg <= pins_next;
      cnt_reg <= cnt_next;
      ph_reg <= ph_next;
      bit_reg <= bit_next;
      left_reg <= left_next;
      shreg_reg <= shreg_next;
      rd_data_reg <= rd_data_next;
      ack_reg <= ack_next;
      rph2_reg <= rph2_next;
      ready_reg <= ready_next;
      wtake_reg <= wtake_next;
      rdv_reg <= rdv_next;
      done_reg <= done_next;
      err_reg <= err_next;
    end
  end

  assign pins = pins_reg;
  assign cmd_ready = ready_reg;
  assign wdata_take = wtake_reg;
  assign rd_data = rd_data_reg;
  assign rd_valid = rdv_reg;
  assign done = done_reg;
  assign nack_err = err_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  start_cond_a: assert property ( // R01
    $rose(pins_reg.sda_oe) && !pins_reg.scl_oe |-> state_reg == ST_START)
    else $error("SDA pulled low with SCL high outside a start");
  sda_stable_a: assert property ( // R02
    (state_reg == ST_SEND || state_reg == ST_RECV) &&
    !pins_reg.scl_oe && $past(!pins_reg.scl_oe) |-> $stable(pins_reg.sda_oe))
    else $error("SDA changed while SCL high inside a byte");
  stop_cond_a: assert property ( // R05
    $fell(pins_reg.sda_oe) && !pins_reg.scl_oe && $past(!pins_reg.scl_oe)
    |-> state_reg == ST_STOP)
    else $error("SDA released with SCL high outside a stop");
  read_phase_a: assert property ( // R06
    byte_end && state_reg == ST_SEND && seq_reg == SQ_SUB && ack_reg &&
    cmd_reg.op == vdh_pkg::OP_READ |=> state_reg == ST_STOP && rph2_reg)
    else $error("Read subaddress not followed by a stop");
  read_dir_a: assert property ( // R07
    $past(state_reg) == ST_START && state_reg == ST_SEND &&
    seq_reg == SQ_AR |-> shreg_reg[0] == vdh_pkg::DIR_READ)
    else $error("Second read phase without read direction");
  master_ack_a: assert property ( // R08
    state_reg == ST_RECV && bit_reg == 4'h8 && ph_reg == 2'h2
    |-> pins_reg.sda_oe == (left_reg != 4'h0))
    else $error("Wrong acknowledge on a read byte");
  stretch_hold_a: assert property ( // R11
    stalled |=> $stable(ph_reg) && $stable(pins_reg.scl_oe))
    else $error("Bit advanced while SCL held low");
  wait_len_a: assert property ( // R12
    $rose(state_reg == ST_HOLD) |->
    cnt_reg == (cmd_reg.reinit ? LONG_LD : WAIT_LD) && pins_reg.scl_oe)
    else $error("Wrong wait before stop");
  no_wait_a: assert property ( // R13
    state_reg == ST_HOLD |-> cmd_reg.subaddr < vdh_pkg::NOWAIT_FIRST)
    else $error("Wait inserted for an upper subaddress");

  write_cov_c: cover property ($fell(state_reg == ST_HOLD));
  read_cov_c: cover property (rd_valid && left_reg == 4'h0);
  nack_cov_c: cover property ($rose(err_reg));
  stretch_cov_c: cover property (stalled [*3]);

endmodule // vdh_host

// >>> sim/vdh_dev_model.sv
// Behavioural decoder register port: two-wire slave with clock stretch.
// Assumes open-drain wires resolved by the bench with pull-ups.
module vdh_dev_model #(
  parameter logic STRAP = 1'h0,
  parameter int STRETCH_NS = 1500
) (
  // Bus wires and presence enable
  input wire logic scl,
  input wire logic sda,
  input wire logic present,
  // Pull-downs and stop timing
  output logic scl_oe,
  output logic sda_oe,
  output int gap_ns
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Slave state
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  int bits;
  int phase = 9;
  time t_ack;
  initial begin
    scl_oe = 1'h0;
    sda_oe = 1'h0;
    gap_ns = 0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  end
  always @(negedge sda) if (scl === 1'h1) begin
    bits = 0;
    phase = 0;
  end
  always @(posedge sda) if (scl === 1'h1) begin
    phase = 9;
    sda_oe = 1'h0;
    gap_ns = int'($time - t_ack);
  end
  always @(posedge scl) begin
    if (phase == 4) begin
      if (bits == 8 && sda === 1'h1) phase = 9;
    end else if (bits < 8) sh = {sh[6:0], sda};
    bits++;
  end
  always @(negedge scl) begin
    if (bits == 8) begin
      sda_oe = 1'h0;
      if (phase == 0) begin
        // Strap fixed from power-up
        if (present && sh[7:1] == {6'h2E, STRAP}) begin
          phase = sh[0] ? 4 : 1;
          sda_oe = 1'h1;
        end else phase = 9;
      end else if (phase < 4) begin
        if (phase == 1) ptr = sh;
        else begin
          mem[ptr] = sh;
          ptr++;
        end
        phase = 2;
        sda_oe = 1'h1;
      end
    end else if (bits == 9) begin
      bits = 0;
      sda_oe = 1'h0;
      if (phase == 2) begin
        t_ack = $time;
        scl_oe = 1'h1;
        #(STRETCH_NS);
        scl_oe = 1'h0;
      end
      if (phase == 4) begin
        sh = mem[ptr];
        ptr++;
      end
    end
    if (phase == 4 && bits < 8) sda_oe = !sh[7 - bits];
  end
endmodule // vdh_dev_model

// >>> sim/tb.sv
// Self-checking bench for the decoder register-access master.
// Assumes two slave models on one pulled-up bus, straps low and high.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WT = 4000;
  localparam int RW = 6000;
  // ==========================================================
  // Signals
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic cmd_valid = 1'h0;
  vdh_pkg::vdh_cmd_t cmd = '0;
  logic [7:0] wdata = 8'h00;
  logic cmd_ready, wdata_take, rd_valid, done, nack_err;
  logic [7:0] rd_data;
  vdh_pkg::vdh_pins_t pins;
  logic m1_on = 1'h1;
  logic s0, d0, s1, d1;
  int g0, g1;
  wire scl = !(pins.scl_oe | s0 | s1);
  wire sda = !(pins.sda_oe | d0 | d1);
  logic [7:0] exp_mem [2][256];
  logic [7:0] seed = 8'h12;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int tno = 0;
  always #2.5 clock = !clock;
  vdh_host #(.WAIT_NS(WT), .REINIT_WAIT_NS(RW)) i_vdh_host (
    .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .wdata(wdata), .wdata_take(wdata_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
    .nack_err(nack_err), .scl_i(scl), .sda_i(sda), .pins(pins));
  vdh_dev_model #(.STRAP(1'h0)) i_vdh_dev_model0 (.scl(scl), .sda(sda),
    .present(1'h1), .scl_oe(s0), .sda_oe(d0), .gap_ns(g0));
  vdh_dev_model #(.STRAP(1'h1)) i_vdh_dev_model1 (.scl(scl), .sda(sda),
    .present(m1_on), .scl_oe(s1), .sda_oe(d1), .gap_ns(g1));
  // ==========================================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic run(input logic op, input logic st, input logic re,
      input logic [7:0] sub, input logic [3:0] n, input logic nk);
    int k;
    int r;
    int g;
    logic ok;
    logic [7:0] cur;
    k = 0;
    r = 0;
    seed = lfsr(seed);
    cur = seed;
    cmd <= '{vdh_pkg::vdh_op_t'(op), st, re, sub, n};
    cmd_valid <= 1'h1;
    wdata <= cur;
    do @(posedge clock); while (cmd_ready !== 1'h1);
    cmd_valid <= 1'h0;
    while (done !== 1'h1) begin
      @(posedge clock);
      if (wdata_take === 1'h1 && k <= n) begin
        exp_mem[st][8'(sub + k)] = cur;
        k++;
        seed = lfsr(seed);
        cur = seed;
        wdata <= cur;
      end
      if (rd_valid === 1'h1) begin
        check("rd_data", rd_data, exp_mem[st][8'(sub + r)]);
        r++;
      end
    end
    check("nack_err", 8'(nack_err), 8'(nk));
    check("cmd_ready", 8'(cmd_ready), 8'h01);
    check("bytes", 8'(op ? r : k), nk ? 8'h00 : 8'(n + 1));
    g = st ? g1 : g0;
    ok = (sub < 8'h90) ? (g >= (re ? RW : WT)) : (g < WT);
    if (!op && !nk) check("stop_wait", 8'(ok), 8'h01);
    tno++;
    $display("test %0d finished", tno);
  endtask
  // ==========================================================
  // Sequence
  always @(posedge clock) begin
    cycles++;
    if (cycles == 100000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    for (int i = 0; i < 256; i++) begin
      exp_mem[0][i] = 8'(i) ^ 8'h5A;
      exp_mem[1][i] = 8'(i) ^ 8'h5A;
    end
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    check("idle_oe", 8'({pins.scl_oe, pins.sda_oe}), 8'h00);
    run(1'h0, 1'h0, 1'h0, 8'h8F, 4'h1, 1'h0);
    run(1'h1, 1'h0, 1'h0, 8'h8F, 4'h1, 1'h0);
    run(1'h0, 1'h1, 1'h0, 8'h90, 4'h0, 1'h0);
    run(1'h0, 1'h1, 1'h1, 8'h05, 4'h0, 1'h0);
    run(1'h1, 1'h1, 1'h0, 8'h05, 4'h0, 1'h0);
    m1_on <= 1'h0;
    run(1'h0, 1'h1, 1'h0, 8'h10, 4'h0, 1'h1);
    stop_test();
  end
endmodule // tb
